// File: hw/ecc_pkg.sv
package ecc_pkg;

	localparam int ADDR_W = 8;
	localparam int DATA_W = 32;

	// register byte offsets
	localparam logic [ADDR_W-1:0] OFF_CTRL = 8'h00;
	localparam logic [ADDR_W-1:0] OFF_MODE = 8'h04;
	localparam logic [ADDR_W-1:0] OFF_STAT = 8'h08;
	localparam logic [ADDR_W-1:0] OFF_PAR = 8'h0c;
	localparam logic [ADDR_W-1:0] OFF_NPAR = 8'h10;

	// field positions and reset values
	localparam int CTRL_RST_BIT = 0;
	localparam int STAT_REC_BIT = 0;
	localparam int STAT_CODE_BIT = 1;
	localparam int STAT_MULT_BIT = 2;
	localparam logic [1:0] MODE_RESET = 2'h0;
	localparam logic [15:0] CODE_RESET = 16'h0000;

	// page geometry: data words and total words for page select 0
	localparam logic [12:0] DATA_WORDS_BASE = 13'h0200;
	localparam logic [12:0] TOTAL_WORDS_BASE = 13'h0210;
	localparam logic [12:0] CODE_WORDS_WIDE = 13'h0002;
	localparam logic [12:0] CODE_WORDS_NARROW = 13'h0004;
	localparam logic [3:0] BIT_MASK_WIDE = 4'hf;
	localparam logic [3:0] BIT_MASK_NARROW = 4'h7;

	localparam logic [1:0] RESP_OKAY = 2'h0;

	typedef enum logic [1:0] {
		ECC_IDLE = 2'h0,
		ECC_DATA = 2'h1,
		ECC_SPARE = 2'h3
	} ecc_phase_t;

	typedef struct packed {
		logic cmd;
		logic cmdRead;
		logic wordValid;
		logic [15:0] word;
	} ecc_flash_t;

	typedef struct packed {
		logic awReady;
		logic wReady;
		logic arReady;
		logic bValid;
		logic rValid;
		logic awHeld;
		logic wHeld;
		logic [ADDR_W-1:0] awAddr;
		logic [DATA_W-1:0] wData;
		logic [3:0] wStrb;
		logic [DATA_W-1:0] rData;
		logic [1:0] mode;
		logic [1:0] pageSel;
		logic wide;
		logic dirRead;
		logic rec;
		logic codeErr;
		logic mult;
		logic [15:0] pr;
		logic [15:0] npr;
		logic [15:0] accP;
		logic [15:0] accN;
		logic [31:0] stored;
		logic [12:0] cnt;
		ecc_phase_t phase;
	} ecc_state_t;

endpackage

// File: hw/ecc_page_regs.sv
// Added by the designer: register access over AXI4-Lite.
`timescale 1ns/1ps
// Summary of operation
// - Writing 1 to control bit 0 clears the parity and inverse parity registers unless a result is written in the same cycle, 0 does nothing.
// - The two-bit page select in the mode register picks 528, 1056, 2112 or 4224 words.
// - A protected word is 8 or 16 bits wide, following the flash organization.
// - The recoverable flag reads 1 on detected data errors, single if the multiple flag is 0.
// - The code error flag reads 1 when one bit of the stored check bytes is wrong.
// - The multiple error flag reads 1 when more than one error is found, else 0.
// - After a single error read the bit offset field holds the corrupted bit position.
// - After a single error read the word field holds the failing word index.
// - Registers sit at 0x00 control, 0x04 mode, 0x08 status, 0x0c and 0x10 parity, all reset 0.
// - Status and both parity registers clear on every flash command, and on a software reset unless a result is written in the same cycle.
// - A 32-bit single-correct double-detect code is built from line and column parity.
// - One bit is correctable per page of 512, 1024, 2048 or 4096 data words.
module ecc_page_regs (
	input wire logic clk,
	input wire logic rst,
	input wire logic [ecc_pkg::ADDR_W-1:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [ecc_pkg::DATA_W-1:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [ecc_pkg::ADDR_W-1:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [ecc_pkg::DATA_W-1:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	input wire ecc_pkg::ecc_flash_t flash,
	input wire logic wideBus
);

	ecc_pkg::ecc_state_t st_reg;
	ecc_pkg::ecc_state_t st_next;

	logic awHs, wHs, arHs;
	logic writeNow, swRst, wordTake, lastData, evalNow, codeNow;
	logic [12:0] dataLen, totalLen, spareIdx, codeWords;
	logic [11:0] wMask;
	logic [3:0] bMask;
	logic [15:0] fullMask, accPn, accNn, sP, sN;
	logic [31:0] storedN;
	logic [8:0] bitX;

	// xor of bit indices over set bits, plain and inverted, plus word parity
	function automatic logic [8:0] ecc_bit_xor(input logic [15:0] d, input logic wide,
		input logic [3:0] m);
		logic [3:0] xb;
		logic [3:0] xn;
		logic odd;
		xb = 4'h0;
		xn = 4'h0;
		odd = 1'b0;
		for (int b = 0; b < 16; b++) begin
			if (d[b] && (wide || b < 8)) begin
				xb = xb ^ 4'(b);
				xn = xn ^ (~4'(b) & m);
				odd = ~odd;
			end
		end
		return {odd, xn, xb};
	endfunction

	always_comb begin
		st_next = st_reg;
		awHs = awvalid && st_reg.awReady;
		wHs = wvalid && st_reg.wReady;
		arHs = arvalid && st_reg.arReady;
		writeNow = st_reg.awHeld && st_reg.wHeld && !st_reg.bValid;

		dataLen = ecc_pkg::DATA_WORDS_BASE << st_reg.pageSel;
		totalLen = ecc_pkg::TOTAL_WORDS_BASE << st_reg.pageSel;
		wMask = 12'(dataLen - 13'h1);
		bMask = st_reg.wide ? ecc_pkg::BIT_MASK_WIDE : ecc_pkg::BIT_MASK_NARROW;
		codeWords = st_reg.wide ? ecc_pkg::CODE_WORDS_WIDE : ecc_pkg::CODE_WORDS_NARROW;
		fullMask = {wMask, bMask};
		spareIdx = st_reg.cnt - dataLen;

		bitX = ecc_bit_xor(flash.word, st_reg.wide, bMask);
		accPn = st_reg.accP ^ {12'h000, bitX[3:0]};
		accNn = st_reg.accN ^ {12'h000, bitX[7:4]};
		if (bitX[8]) begin
			accPn = accPn ^ {st_reg.cnt[11:0], 4'h0};
			accNn = accNn ^ {~st_reg.cnt[11:0] & wMask, 4'h0};
		end

		// stored code arrives little-endian at the head of the spare area
		storedN = st_reg.wide ? {flash.word, st_reg.stored[31:16]}
			: {flash.word[7:0], st_reg.stored[31:8]};
		sP = st_reg.accP ^ storedN[15:0];
		sN = st_reg.accN ^ storedN[31:16];

		// a command in the same cycle as a word wins; the word is dropped
		wordTake = flash.wordValid && !flash.cmd;
		lastData = wordTake && st_reg.phase == ecc_pkg::ECC_DATA
			&& st_reg.cnt == dataLen - 13'h1;
		codeNow = wordTake && st_reg.phase == ecc_pkg::ECC_SPARE && st_reg.dirRead
			&& spareIdx < codeWords;
		evalNow = codeNow && spareIdx == codeWords - 13'h1;
		swRst = writeNow && st_reg.awAddr == ecc_pkg::OFF_CTRL && st_reg.wStrb[0]
			&& st_reg.wData[ecc_pkg::CTRL_RST_BIT];

		// bus channel bookkeeping
		if (awHs) begin
			st_next.awHeld = 1'b1;
			st_next.awAddr = awaddr;
		end
		if (wHs) begin
			st_next.wHeld = 1'b1;
			st_next.wData = wdata;
			st_next.wStrb = wstrb;
		end
		if (st_reg.bValid && bready) begin
			st_next.bValid = 1'b0;
		end
		if (st_reg.rValid && rready) begin
			st_next.rValid = 1'b0;
		end
		if (writeNow) begin
			st_next.bValid = 1'b1;
			st_next.awHeld = 1'b0;
			st_next.wHeld = 1'b0;
			if (st_reg.awAddr == ecc_pkg::OFF_MODE && st_reg.wStrb[0]) begin
				st_next.mode = st_reg.wData[1:0];
			end
		end

		// register map, reserved and write-only read zero
		if (arHs) begin
			st_next.rValid = 1'b1;
			case (araddr)
				ecc_pkg::OFF_MODE: st_next.rData = 32'(st_reg.mode);
				ecc_pkg::OFF_STAT: st_next.rData = 32'({st_reg.mult, st_reg.codeErr, st_reg.rec});
				ecc_pkg::OFF_PAR: st_next.rData = 32'(st_reg.pr);
				ecc_pkg::OFF_NPAR: st_next.rData = 32'(st_reg.npr);
				default: st_next.rData = 32'h0000_0000;
			endcase
		end

		case (st_reg.phase)
			ecc_pkg::ECC_DATA: begin
				if (wordTake) begin
					st_next.accP = accPn;
					st_next.accN = accNn;
					st_next.cnt = st_reg.cnt + 13'h1;
					if (lastData) begin
						st_next.pr = accPn;
						st_next.npr = accNn;
						st_next.phase = ecc_pkg::ECC_SPARE;
					end
				end
			end
			ecc_pkg::ECC_SPARE: begin
				if (wordTake) begin
					st_next.cnt = st_reg.cnt + 13'h1;
					// code words fetched from the spare area
					if (codeNow) begin
						st_next.stored = storedN;
					end
					if (st_reg.cnt == totalLen - 13'h1) begin
						st_next.phase = ecc_pkg::ECC_IDLE;
					end
				end
			end
			default: st_next.phase = ecc_pkg::ECC_IDLE;
		endcase

		if (evalNow) begin
			// syndrome left in both parity registers
			st_next.pr = sP;
			st_next.npr = sN;
			if ({sP, sN} != 32'h0) begin
				if ($onehot({sP, sN})) begin
					st_next.codeErr = 1'b1;
				end else if ((sP ^ sN) == fullMask && ((sP | sN) & ~fullMask) == 16'h0) begin
					st_next.rec = 1'b1;
				end else begin
					st_next.rec = 1'b1;
					st_next.mult = 1'b1;
				end
			end
		end

		// software parity reset, a same-cycle result wins
		if (swRst) begin
			st_next.accP = ecc_pkg::CODE_RESET;
			st_next.accN = ecc_pkg::CODE_RESET;
			st_next.cnt = 13'h0;
			st_next.phase = ecc_pkg::ECC_IDLE;
			if (!lastData && !evalNow) begin
				st_next.pr = ecc_pkg::CODE_RESET;
				st_next.npr = ecc_pkg::CODE_RESET;
				st_next.rec = 1'b0;
				st_next.codeErr = 1'b0;
				st_next.mult = 1'b0;
			end
		end

		if (flash.cmd) begin
			st_next.pr = ecc_pkg::CODE_RESET;
			st_next.npr = ecc_pkg::CODE_RESET;
			st_next.rec = 1'b0;
			st_next.codeErr = 1'b0;
			st_next.mult = 1'b0;
			st_next.accP = ecc_pkg::CODE_RESET;
			st_next.accN = ecc_pkg::CODE_RESET;
			st_next.cnt = 13'h0;
			st_next.stored = 32'h0000_0000;
			st_next.dirRead = flash.cmdRead;
			st_next.wide = wideBus;
			// page size is frozen per transfer so a mid-page write cannot skew it
			st_next.pageSel = st_reg.mode;
			st_next.phase = ecc_pkg::ECC_DATA;
		end

		st_next.awReady = !st_next.awHeld && !st_next.bValid;
		st_next.wReady = !st_next.wHeld && !st_next.bValid;
		st_next.arReady = !st_next.rValid;
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st_reg <= '0;
			st_reg.mode <= ecc_pkg::MODE_RESET;
			st_reg.phase <= ecc_pkg::ECC_IDLE;
		end else begin
			st_reg <= st_next;
		end
	end

	assign awready = st_reg.awReady;
	assign wready = st_reg.wReady;
	assign arready = st_reg.arReady;
	assign bvalid = st_reg.bValid;
	assign rvalid = st_reg.rValid;
	assign rdata = st_reg.rData;
	// only OKAY is ever answered
	assign bresp = ecc_pkg::RESP_OKAY;
	assign rresp = ecc_pkg::RESP_OKAY;

	default clocking cb @(posedge clk);
	endclocking
	default disable iff (rst);

	property p_sw_reset;
		swRst && !lastData && !evalNow && !flash.cmd |=> st_reg.pr == 16'h0 && st_reg.npr == 16'h0;
	endproperty
	a_sw_reset: assert property (p_sw_reset) else $error("parity not cleared by control write");

	property p_page_len;
		lastData && !swRst |=> st_reg.phase == ecc_pkg::ECC_SPARE && st_reg.cnt == dataLen;
	endproperty
	a_page_len: assert property (p_page_len) else $error("data area length wrong");

	property p_narrow_bit;
		st_reg.rec && !st_reg.mult && !st_reg.wide |-> !st_reg.pr[3];
	endproperty
	a_narrow_bit: assert property (p_narrow_bit) else $error("bit offset beyond byte");

	property p_mult_rec;
		st_reg.mult |-> st_reg.rec && !st_reg.codeErr;
	endproperty
	a_mult_rec: assert property (p_mult_rec) else $error("multiple without recoverable");

	property p_code_err;
		evalNow && !flash.cmd && $onehot({sP, sN}) |=> st_reg.codeErr && !st_reg.rec;
	endproperty
	a_code_err: assert property (p_code_err) else $error("check byte fault not flagged");

	property p_single;
		evalNow && (sP ^ sN) == fullMask && ((sP | sN) & ~fullMask) == 16'h0
			|=> st_reg.rec && !st_reg.mult && st_reg.pr == $past(sP);
	endproperty
	a_single: assert property (p_single) else $error("single error misreported");

	property p_word_idx;
		st_reg.rec && !st_reg.mult |-> (st_reg.pr[15:4] & ~wMask) == 12'h0;
	endproperty
	a_word_idx: assert property (p_word_idx) else $error("word index past page");

	property p_cmd_clear;
		flash.cmd |=> !st_reg.rec && !st_reg.codeErr && !st_reg.mult && st_reg.pr == 16'h0
			&& st_reg.npr == 16'h0 && st_reg.phase == ecc_pkg::ECC_DATA && st_reg.cnt == 13'h0;
	endproperty
	a_cmd_clear: assert property (p_cmd_clear) else $error("command did not clear results");

	property p_prog_end;
		lastData && !st_reg.dirRead |=> st_reg.pr == $past(accPn) && st_reg.npr == $past(accNn);
	endproperty
	a_prog_end: assert property (p_prog_end) else $error("parity not ready at page end");

	property p_write_resp;
		writeNow |=> bvalid ##1 (bvalid || $past(bready));
	endproperty
	a_write_resp: assert property (p_write_resp) else $error("write answer missing");

	property p_read_hold;
		rvalid && !rready |=> rvalid && $stable(rdata);
	endproperty
	a_read_hold: assert property (p_read_hold) else $error("read data dropped");

	property p_read_resp;
		arvalid && arready |=> rvalid;
	endproperty
	a_read_resp: assert property (p_read_resp) else $error("read answer missing");

	property p_sw_status;
		swRst && !lastData && !evalNow |=> !st_reg.rec && !st_reg.codeErr && !st_reg.mult;
	endproperty
	a_sw_status: assert property (p_sw_status) else $error("status kept after reset");

	property p_cmd_latch;
		flash.cmd |=> st_reg.wide == $past(wideBus) && st_reg.pageSel == $past(st_reg.mode)
			&& st_reg.dirRead == $past(flash.cmdRead);
	endproperty
	a_cmd_latch: assert property (p_cmd_latch) else $error("page setup not latched");

	property p_multiple;
		evalNow && {sP, sN} != 32'h0 && !$onehot({sP, sN})
			&& !((sP ^ sN) == fullMask && ((sP | sN) & ~fullMask) == 16'h0) |=> st_reg.mult;
	endproperty
	a_multiple: assert property (p_multiple) else $error("multiple error not flagged");

	property p_spare_end;
		wordTake && st_reg.phase == ecc_pkg::ECC_SPARE && st_reg.cnt == totalLen - 13'h1
			|=> st_reg.phase == ecc_pkg::ECC_IDLE;
	endproperty
	a_spare_end: assert property (p_spare_end) else $error("page did not end");

	c_correct: cover property (evalNow ##1 st_reg.rec && !st_reg.mult);
	c_code: cover property (evalNow ##1 st_reg.codeErr);
	c_multi: cover property (evalNow ##1 st_reg.mult);
	c_prog: cover property (lastData && !st_reg.dirRead);

endmodule // ecc_page_regs

// File: sim/ecc_flash_model.sv
`timescale 1ns/1ps
module ecc_flash_model (
	input wire logic clk,
	input wire logic rst,
	input wire logic go,
	input wire logic goRead,
	input wire logic [1:0] sel,
	output ecc_pkg::ecc_flash_t flash,
	output logic busy
);
	logic [15:0] mem [0:4223];
	logic [7:0] gapReg;
	int total;
	initial begin
		flash = '0;
		busy = 1'b0;
		gapReg = 8'h5a;
		forever begin
			@(posedge clk);
			// bus not owned: keep the word moving so stale data is never trusted
			flash.word <= ~flash.word;
			if (go && !rst) begin
				total = 528 << sel;
				busy <= 1'b1;
				flash.cmd <= 1'b1;
				flash.cmdRead <= goRead;
				@(posedge clk);
				flash.cmd <= 1'b0;
				for (int i = 0; i < total; i++) begin
					// slow flash: random idle cycles between words
					repeat (gapReg[1:0]) begin
						flash.wordValid <= 1'b0;
						flash.word <= ~flash.word;
						@(posedge clk);
					end
					gapReg = {gapReg[6:0], gapReg[7] ^ gapReg[5] ^ gapReg[4] ^ gapReg[3]};
					flash.wordValid <= 1'b1;
					flash.word <= mem[i];
					@(posedge clk);
				end
				flash.wordValid <= 1'b0;
				flash.word <= ~mem[total - 1];
				busy <= 1'b0;
			end
		end
	end
endmodule // ecc_flash_model

// File: sim/test_nand_page_ecc_registers.sv
`timescale 1ns/1ps
module test_nand_page_ecc_registers;
	logic clk, rst, awvalid, wvalid, bready, arvalid, rready, wideBus, go, goRead, busy;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rngState, code;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, selQ;
	ecc_pkg::ecc_flash_t flash;
	logic [31:0] expQ[$];
	string nameQ[$];
	int bad_count = 0;
	int num_checks = 0;
	int cycles = 0;
	int k, b;
	logic [2:0] statTab [0:3] = '{3'h0, 3'h1, 3'h5, 3'h2};
	logic [7:0] addrTab [0:6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'hfc};

	ecc_page_regs dut_u (.clk(clk), .rst(rst), .awaddr(awaddr), .awvalid(awvalid),
		.awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
		.arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
		.flash(flash), .wideBus(wideBus));
	ecc_flash_model flashU (.clk(clk), .rst(rst), .go(go), .goRead(goRead), .sel(selQ),
		.flash(flash), .busy(busy));

	initial begin
		clk = 1'b0;
		forever #25 clk = ~clk;
	end

	task automatic results();
		if (bad_count == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		num_checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("mismatch %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	always @(posedge clk) begin
		cycles <= cycles + 1;
		if (rvalid === 1'b1 && rready === 1'b1 && expQ.size() > 0) begin
			check(nameQ.pop_front(), rdata, expQ.pop_front());
			check("read response", 32'(rresp), 32'(ecc_pkg::RESP_OKAY));
		end
		if (bvalid === 1'b1 && bready === 1'b1)
			check("write response", 32'(bresp), 32'(ecc_pkg::RESP_OKAY));
		if (cycles == 80000) begin
			bad_count++;
			results();
		end
	end

	function automatic logic [31:0] rnd();
		rngState ^= rngState << 13;
		rngState ^= rngState >> 17;
		rngState ^= rngState << 5;
		return rngState;
	endfunction

	// code as the block should build it: xor of bit addresses and their masked inverse
	function automatic logic [31:0] calc(input int s, input logic w);
		logic [15:0] p, n, m, a;
		p = 16'h0000;
		n = 16'h0000;
		m = 16'(((512 << s) - 1) << 4) | (w ? 16'h000f : 16'h0007);
		for (int i = 0; i < (512 << s); i++)
			for (int j = 0; j < (w ? 16 : 8); j++)
				if (flashU.mem[i][j] === 1'b1) begin
					a = 16'(i * 16 + j);
					p ^= a;
					n ^= ~a & m;
				end
		return {n, p};
	endfunction

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge clk);
			if (awready === 1'b1)
				awvalid <= 1'b0;
			if (wready === 1'b1)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a, input logic [31:0] e, input string nm);
		expQ.push_back(e);
		nameQ.push_back(nm);
		@(posedge clk);
		araddr <= a;
		arvalid <= 1'b1;
		do @(posedge clk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		rready <= 1'b1;
		do @(posedge clk); while (rvalid !== 1'b1);
		rready <= 1'b0;
	endtask

	task automatic run(input logic [1:0] s, input logic r, input logic waitEnd);
		@(posedge clk);
		go <= 1'b1;
		goRead <= r;
		selQ <= s;
		@(posedge clk);
		go <= 1'b0;
		if (waitEnd)
			do @(posedge clk); while (busy === 1'b1);
	endtask

	task automatic flip(input int c);
		if (c == 1 || c == 2)
			flashU.mem[k][b] = ~flashU.mem[k][b];
		if (c == 2)
			flashU.mem[k ^ 1][b] = ~flashU.mem[k ^ 1][b];
		if (c == 3)
			flashU.mem[512][0] = ~flashU.mem[512][0];
	endtask

	initial begin
		rst = 1'b1;
		{awvalid, wvalid, bready, arvalid, rready, wideBus, go, goRead} = 8'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'hf;
		selQ = 2'h0;
		rngState = 32'h0000005d;
		for (int i = 0; i < 4224; i++)
			flashU.mem[i] = 16'(rnd());
		repeat (5) @(posedge clk);
		rst <= 1'b0;
		foreach (addrTab[i])
			rd(addrTab[i], 32'h0, "reset value");
		wr(ecc_pkg::OFF_MODE, 32'h3);
		rd(ecc_pkg::OFF_MODE, 32'h3, "mode");
		wr(ecc_pkg::OFF_STAT, 32'h7);
		rd(ecc_pkg::OFF_STAT, 32'h0, "status read-only");
		for (int s = 0; s < 4; s++) begin
			wideBus <= 1'(s);
			wr(ecc_pkg::OFF_MODE, 32'(s));
			run(2'(s), 1'b0, 1'b1);
			code = calc(s, 1'(s));
			rd(ecc_pkg::OFF_PAR, {16'h0, code[15:0]}, "parity");
			rd(ecc_pkg::OFF_NPAR, {16'h0, code[31:16]}, "inverse");
		end
		wideBus <= 1'b0;
		wr(ecc_pkg::OFF_MODE, 32'h0);
		code = calc(0, 1'b0);
		// software stores the code in the first spare bytes
		for (int i = 0; i < 4; i++)
			flashU.mem[512 + i] = {8'h00, code[8 * i +: 8]};
		for (int c = 0; c < 4; c++) begin
			k = int'(rnd() % 512);
			b = int'(rnd() % 8);
			flip(c);
			run(2'h0, 1'b1, 1'b1);
			rd(ecc_pkg::OFF_STAT, {29'h0, statTab[c]}, "status");
			if (c == 1)
				rd(ecc_pkg::OFF_PAR, 32'(k * 16 + b), "location");
			if (c == 0)
				rd(ecc_pkg::OFF_NPAR, 32'h0, "clean syndrome");
			if (c == 3)
				rd(ecc_pkg::OFF_PAR, 32'h1, "code fault position");
			if (c == 3)
				rd(ecc_pkg::OFF_NPAR, 32'h0, "code fault inverse");
			flip(c);
		end
		run(2'h0, 1'b0, 1'b0);
		rd(ecc_pkg::OFF_STAT, 32'h0, "status after command");
		do @(posedge clk); while (busy === 1'b1);
		// reset bit without its byte strobe must not clear
		wstrb <= 4'he;
		wr(ecc_pkg::OFF_CTRL, 32'h1);
		rd(ecc_pkg::OFF_PAR, {16'h0, code[15:0]}, "strobe ignored");
		wstrb <= 4'hf;
		wr(ecc_pkg::OFF_CTRL, 32'h0);
		rd(ecc_pkg::OFF_PAR, {16'h0, code[15:0]}, "parity kept");
		wr(ecc_pkg::OFF_CTRL, 32'h1);
		rd(ecc_pkg::OFF_PAR, 32'h0, "parity cleared");
		rd(ecc_pkg::OFF_NPAR, 32'h0, "inverse cleared");
		rd(ecc_pkg::OFF_CTRL, 32'h0, "control write-only");
		repeat (2) @(posedge clk);
		results();
	end
endmodule // test_nand_page_ecc_registers
